// ### logic/psm_ctrl.sv
// Processor state and privilege mode controller
//
// How it works
// - Power-on reset pin low holds the controller in power-on reset state.
// - Manual reset pin low, with the power-on reset pin high, holds the controller in manual reset state.
// - Power-on reset initialises core state and all module registers including bus controller.
// - Manual reset initialises core and module registers but keeps bus controller registers.
// - Leaving reset passes exception state and fetches from fixed reset vector.
// - General exception or interrupt saves PC and status word.
// - Handler address is vector base plus event vector offset.
// - Execute state steps instructions in order until something intervenes.
// - Power-down halts core; sleep, software standby, hardware standby.
// - External bus request releases the bus until the requester returns it.
// - Status mode bit 0 is user mode, 1 privileged.
// - Entering reset or exception sets mode bit to 1.
// - Exception return clears the mode bit to 0.
// - Some registers and bits are reachable only in privileged mode.
`timescale 1ns/1ps
`default_nettype none
module psm_ctrl
	import psm_pkg::*;
(
	input wire logic clock, // Core clock, 10 MHz
	input wire logic rst_n, // Asynchronous chip reset, active low
	input wire logic power_on_reset_n, // Power-on reset pin, active low
	input wire logic manual_reset_n, // Manual reset pin, active low
	input wire logic bus_request, // External master asks for the bus (pin)
	input wire logic exc_request, // General exception or interrupt, one cycle
	input wire logic [31:0] exc_offset, // Vector offset of that event
	input wire logic [31:0] current_pc, // PC of the instruction being executed
	input wire logic [31:0] vector_base, // Vector base address
	input wire logic exc_return, // Exception handling ends, one cycle
	input wire logic sleep_request, // Enter power-down, one cycle
	input wire psm_pd_mode_t sleep_mode, // Variant of power-down requested
	input wire logic wake_event, // Wake from power-down, one cycle
	input wire logic priv_access, // Access to a privileged-only register or bit
	input wire logic status_load, // Software writes the status word
	input wire logic [31:0] status_wdata, // Value written to the status word
	output psm_state_t state, // Current processor state
	output logic [31:0] status_word, // Status word
	output logic privilege_mode_bit, // 1 privileged, 0 user
	output logic [31:0] saved_pc_reg, // Saved program counter
	output logic [31:0] saved_status_reg, // Saved status word
	output logic [31:0] fetch_addr, // Address to fetch after a branch
	output logic fetch_load, // Fetch address valid, one cycle
	output logic exec_enable, // Core may step instructions
	output logic bus_grant, // Bus released to the external master
	output logic module_init, // Initialise on-chip module registers
	output logic bsc_init, // Initialise bus_state_controller registers
	output psm_pd_mode_t pd_mode, // Active power-down variant
	output logic priv_grant, // Privileged access allowed
	output logic priv_fault // Privileged access refused, one cycle
);
	//------------------------------------------------------------
	// Pin synchronisers
	//------------------------------------------------------------
	logic pon_n_s;
	logic man_n_s;
	logic breq_s;

	psm_sync #(.RESET_VALUE(1'b0)) u_sync_pon (
		.clock(clock),
		.rst_n(rst_n),
		.async_in(power_on_reset_n),
		.sync_out(pon_n_s)
	);
	psm_sync #(.RESET_VALUE(1'b1)) u_sync_man (
		.clock(clock),
		.rst_n(rst_n),
		.async_in(manual_reset_n),
		.sync_out(man_n_s)
	);
	psm_sync #(.RESET_VALUE(1'b0)) u_sync_breq (
		.clock(clock),
		.rst_n(rst_n),
		.async_in(bus_request),
		.sync_out(breq_s)
	);

	//------------------------------------------------------------
	// Decode
	//------------------------------------------------------------
	wire in_reset = (state == PSM_ST_PON_RESET) || (state == PSM_ST_MAN_RESET);
	wire executing = (state == PSM_ST_EXECUTE);
	// Power-on reset wins over manual reset when both pins are low
	wire pon_active = !pon_n_s;
	wire man_active = pon_n_s && !man_n_s;
	wire user_access = executing && priv_access && !privilege_mode_bit;
	wire take_exc = executing && (exc_request || user_access);
	wire [31:0] exc_vec = user_access ? PSM_PRIV_VIOL_OFFSET : exc_offset;
	wire [31:0] handler_addr = vector_base + exc_vec;
	wire [31:0] status_priv = status_word | (32'h00000001 << PSM_MODE_BIT_POS);
	wire [31:0] status_user = status_word & ~(32'h00000001 << PSM_MODE_BIT_POS);

	//------------------------------------------------------------
	// State machine
	//------------------------------------------------------------
	psm_state_t next_state;

	always_comb begin
		next_state = state;
		if (pon_active) begin
			next_state = PSM_ST_PON_RESET;
		end else if (man_active) begin
			next_state = PSM_ST_MAN_RESET;
		end else begin
			case (state)
				PSM_ST_PON_RESET, PSM_ST_MAN_RESET: next_state = PSM_ST_EXCEPTION;
				PSM_ST_EXCEPTION: next_state = PSM_ST_EXECUTE;
				PSM_ST_EXECUTE: begin
					// Bus request is honoured before a pending exception or sleep
					if (breq_s) begin
						next_state = PSM_ST_BUS_RELEASED;
					end else if (take_exc) begin
						next_state = PSM_ST_EXCEPTION;
					end else if (sleep_request) begin
						next_state = PSM_ST_POWER_DOWN;
					end else begin
						next_state = PSM_ST_EXECUTE;
					end
				end
				PSM_ST_POWER_DOWN: begin
					if (wake_event) begin
						next_state = PSM_ST_EXECUTE;
					end
				end
				PSM_ST_BUS_RELEASED: begin
					if (!breq_s) begin
						next_state = PSM_ST_EXECUTE;
					end
				end
				default: next_state = PSM_ST_PON_RESET;
			endcase
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= PSM_ST_PON_RESET;
		end else begin
			state <= next_state;
		end
	end

	//------------------------------------------------------------
	// Status word, saved registers and fetch vector
	//------------------------------------------------------------
	// A hardware entry into exception or reset beats a same-cycle software load
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			status_word <= PSM_STATUS_RESET;
			saved_pc_reg <= PSM_PC_RESET;
			saved_status_reg <= PSM_STATUS_RESET;
			fetch_addr <= PSM_RESET_VECTOR;
			fetch_load <= 1'b0;
		end else begin
			fetch_load <= 1'b0;
			if (pon_active || man_active) begin
				status_word <= PSM_STATUS_RESET;
				fetch_addr <= PSM_RESET_VECTOR;
			end else if (in_reset) begin
				fetch_addr <= PSM_RESET_VECTOR;
				fetch_load <= 1'b1;
			end else if (take_exc && !breq_s) begin
				saved_pc_reg <= current_pc;
				saved_status_reg <= status_word;
				status_word <= status_priv;
				fetch_addr <= handler_addr;
				fetch_load <= 1'b1;
			end else if (executing && exc_return) begin
				status_word <= status_user;
				fetch_addr <= saved_pc_reg;
				fetch_load <= 1'b1;
			end else if (executing && status_load && privilege_mode_bit) begin
				status_word <= status_wdata;
			end
		end
	end

	//------------------------------------------------------------
	// Registered outputs
	//------------------------------------------------------------
	wire [31:0] next_status_bit_src = status_word;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			privilege_mode_bit <= 1'b1;
			exec_enable <= 1'b0;
			bus_grant <= 1'b0;
			module_init <= 1'b1;
			bsc_init <= 1'b1;
			pd_mode <= PSM_PD_SLEEP;
			priv_grant <= 1'b0;
			priv_fault <= 1'b0;
		end else begin
			privilege_mode_bit <= next_status_bit_src[PSM_MODE_BIT_POS];
			exec_enable <= (next_state == PSM_ST_EXECUTE);
			bus_grant <= (next_state == PSM_ST_BUS_RELEASED);
			module_init <= pon_active || man_active;
			bsc_init <= pon_active;
			if (executing && sleep_request && !breq_s && !take_exc) begin
				pd_mode <= sleep_mode;
			end
			priv_grant <= executing && priv_access && privilege_mode_bit;
			priv_fault <= user_access;
		end
	end

	//------------------------------------------------------------
	// Assertions
	//------------------------------------------------------------
	sequence s_exc_taken;
		state == PSM_ST_EXECUTE && exc_request && !breq_s && pon_n_s && man_n_s;
	endsequence

	sequence s_reset_leave;
		(state == PSM_ST_PON_RESET || state == PSM_ST_MAN_RESET) && pon_n_s && man_n_s;
	endsequence

	sequence s_wake_up;
		state == PSM_ST_POWER_DOWN && wake_event && pon_n_s && man_n_s;
	endsequence

	sequence s_bus_back;
		state == PSM_ST_BUS_RELEASED && !breq_s && pon_n_s && man_n_s;
	endsequence

	a_pon_hold: assert property (@(posedge clock) disable iff (!rst_n)
		!pon_n_s |=> state == PSM_ST_PON_RESET)
		else $error("power-on reset not held");
	a_man_hold: assert property (@(posedge clock) disable iff (!rst_n)
		pon_n_s && !man_n_s |=> state == PSM_ST_MAN_RESET)
		else $error("manual reset not held");
	a_bsc_scope: assert property (@(posedge clock) disable iff (!rst_n)
		pon_n_s && !man_n_s |=> module_init && !bsc_init)
		else $error("manual reset touched bus controller");
	a_pon_scope: assert property (@(posedge clock) disable iff (!rst_n)
		!pon_n_s |=> module_init && bsc_init)
		else $error("power-on reset scope wrong");
	a_reset_vector: assert property (@(posedge clock) disable iff (!rst_n)
		s_reset_leave |=> state == PSM_ST_EXCEPTION && fetch_load && fetch_addr == PSM_RESET_VECTOR
		##1 state == PSM_ST_EXECUTE || !pon_n_s || !man_n_s)
		else $error("reset exit not through reset vector");
	a_exc_save: assert property (@(posedge clock) disable iff (!rst_n)
		s_exc_taken |=> saved_pc_reg == $past(current_pc) && saved_status_reg == $past(status_word))
		else $error("exception did not save context");
	a_exc_vector: assert property (@(posedge clock) disable iff (!rst_n)
		s_exc_taken and (!priv_access || privilege_mode_bit)
		|=> fetch_addr == $past(vector_base) + $past(exc_offset) && fetch_load)
		else $error("handler address wrong");
	a_mode_set: assert property (@(posedge clock) disable iff (!rst_n)
		s_exc_taken |=> ##1 privilege_mode_bit)
		else $error("mode bit not set on exception");
	a_mode_clear: assert property (@(posedge clock) disable iff (!rst_n)
		state == PSM_ST_EXECUTE && exc_return && !exc_request && !priv_access && !breq_s && pon_n_s && man_n_s
		|=> ##1 !privilege_mode_bit)
		else $error("mode bit not cleared on return");
	a_bus_release: assert property (@(posedge clock) disable iff (!rst_n)
		state == PSM_ST_EXECUTE && breq_s && pon_n_s && man_n_s |=> bus_grant && state == PSM_ST_BUS_RELEASED)
		else $error("bus not released");
	a_user_fault: assert property (@(posedge clock) disable iff (!rst_n)
		state == PSM_ST_EXECUTE && priv_access && !privilege_mode_bit |=> priv_fault && !priv_grant)
		else $error("user access to privileged resource not refused");
	a_pd_halt: assert property (@(posedge clock) disable iff (!rst_n)
		state == PSM_ST_POWER_DOWN |-> !exec_enable || $past(wake_event))
		else $error("core runs in power-down");
	// exec_enable and bus_grant must never disagree with the state; privilege_mode_bit follows the status word one cycle late
	a_exec_flag: assert property (@(posedge clock) disable iff (!rst_n)
		exec_enable == (state == PSM_ST_EXECUTE))
		else $error("run enable disagrees with state");
	a_grant_flag: assert property (@(posedge clock) disable iff (!rst_n)
		bus_grant == (state == PSM_ST_BUS_RELEASED))
		else $error("bus grant disagrees with state");
	a_mode_track: assert property (@(posedge clock) disable iff (!rst_n)
		privilege_mode_bit == $past(status_word[PSM_MODE_BIT_POS]))
		else $error("mode bit does not follow status word");
	a_exc_transient: assert property (@(posedge clock) disable iff (!rst_n)
		state == PSM_ST_EXCEPTION && pon_n_s && man_n_s |=> state == PSM_ST_EXECUTE)
		else $error("exception state not left after one cycle");
	a_bus_hold: assert property (@(posedge clock) disable iff (!rst_n)
		state == PSM_ST_BUS_RELEASED && breq_s && pon_n_s && man_n_s
		|=> state == PSM_ST_BUS_RELEASED && bus_grant)
		else $error("bus taken back while still requested");
	a_bus_return: assert property (@(posedge clock) disable iff (!rst_n)
		s_bus_back |=> state == PSM_ST_EXECUTE && !bus_grant)
		else $error("bus not taken back after release");
	a_pd_enter: assert property (@(posedge clock) disable iff (!rst_n)
		state == PSM_ST_EXECUTE && sleep_request && !exc_request && !priv_access && !breq_s && pon_n_s && man_n_s
		|=> state == PSM_ST_POWER_DOWN && pd_mode == $past(sleep_mode) && !exec_enable)
		else $error("power-down not entered");
	a_pd_wake: assert property (@(posedge clock) disable iff (!rst_n)
		s_wake_up |=> state == PSM_ST_EXECUTE && exec_enable)
		else $error("power-down not left on wake");
	a_priv_grant: assert property (@(posedge clock) disable iff (!rst_n)
		state == PSM_ST_EXECUTE && priv_access && privilege_mode_bit |=> priv_grant && !priv_fault)
		else $error("privileged access refused in privileged mode");
	// A user-mode write must leave the status word alone, else the mode bit could be raised by software
	a_status_guard: assert property (@(posedge clock) disable iff (!rst_n)
		state == PSM_ST_EXECUTE && status_load && !privilege_mode_bit && !exc_request && !exc_return
		&& !priv_access && pon_n_s && man_n_s |=> status_word == $past(status_word))
		else $error("user mode wrote the status word");
	// The fault always leaves the execute state, so it can never repeat on the next edge
	a_fault_pulse: assert property (@(posedge clock) disable iff (!rst_n)
		priv_fault |=> !priv_fault)
		else $error("fault flag held for more than one cycle");
endmodule // psm_ctrl
`default_nettype wire

// ### logic/psm_pkg.sv
// Package: constants and types for the processor state and mode controller
package psm_pkg;
	localparam int PSM_ADDR_W = 32;
	localparam logic [31:0] PSM_RESET_VECTOR = 32'hA0000000;
	localparam logic [31:0] PSM_STATUS_RESET = 32'h700000F0;
	localparam int PSM_MODE_BIT_POS = 30;
	localparam logic [31:0] PSM_PRIV_VIOL_OFFSET = 32'h00000100;
	localparam logic [31:0] PSM_PC_RESET = 32'h00000000;
	localparam logic [31:0] PSM_VBR_RESET = 32'h00000000;
	localparam logic [31:0] PSM_BSC_RESET = 32'h00000000;

	typedef enum logic [2:0] {
		PSM_ST_PON_RESET,
		PSM_ST_MAN_RESET,
		PSM_ST_EXCEPTION,
		PSM_ST_EXECUTE,
		PSM_ST_POWER_DOWN,
		PSM_ST_BUS_RELEASED
	} psm_state_t;

	typedef enum logic [1:0] {
		PSM_PD_SLEEP,
		PSM_PD_SW_STANDBY,
		PSM_PD_HW_STANDBY
	} psm_pd_mode_t;
endpackage

// ### logic/psm_sync.sv
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none
module psm_sync #(
	parameter logic RESET_VALUE = 1'b0
) (
	input wire logic clock, // Core clock
	input wire logic rst_n, // Asynchronous reset, active low
	input wire logic async_in, // Level from outside the clock domain
	output logic sync_out // Synchronised level
);
	logic stage1;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= RESET_VALUE;
			sync_out <= RESET_VALUE;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule // psm_sync
`default_nettype wire

// ### tb/psm_ext_party.sv
// Model of the reset sources and the bus-requesting external master
`timescale 1ns/1ps
`default_nettype none
module psm_ext_party (
	input wire logic clock, // Core clock, used only to pace the model
	input wire logic por_cmd, // Bench asks for power-on reset
	input wire logic man_cmd, // Bench asks for manual reset
	input wire logic want_bus, // Bench asks the master to take the bus
	input wire logic [3:0] hold_cycles, // Granted cycles before the bus is returned
	input wire logic bus_grant, // Grant seen from the controller
	output logic power_on_reset_n, // Power-on reset pin
	output logic manual_reset_n, // Manual reset pin
	output logic bus_request // Bus request pin
);
	logic [3:0] used = 4'h0;
	initial begin
		power_on_reset_n = 1'b1;
		manual_reset_n = 1'b1;
		bus_request = 1'b0;
	end
	// Pins move off the clock edge, as true asynchronous levels would
	always @(posedge clock) begin
		#3;
		power_on_reset_n = !por_cmd;
		manual_reset_n = !man_cmd;
		if (!want_bus) begin
			bus_request = 1'b0;
			used = 4'h0;
		end else if (used < hold_cycles) begin
			bus_request = 1'b1;
			if (bus_grant) used = used + 4'h1;
		end else begin
			bus_request = 1'b0;
		end
	end
endmodule // psm_ext_party
`default_nettype wire

// ### tb/tb_psm_ctrl.sv
// Self-checking bench for the processor state and mode controller
`timescale 1ns/1ps
`default_nettype none
module tb_psm_ctrl
	import psm_pkg::*;
;
	logic clock = 0, rst_n = 0, exc_request = 0, exc_return = 0, sleep_request = 0, wake_event = 0;
	logic priv_access = 0, status_load = 0, want_bus = 0, por_cmd = 0, man_cmd = 0;
	logic [3:0] hold_cycles = 4'h3;
	logic [31:0] exc_offset = 0, current_pc = 0, vector_base = 0, status_wdata = 0, exp_ssr;
	psm_pd_mode_t sleep_mode = PSM_PD_SLEEP, pd_mode;
	psm_state_t state;
	logic [31:0] status_word, saved_pc_reg, saved_status_reg, fetch_addr;
	logic privilege_mode_bit, fetch_load, exec_enable, bus_grant, module_init, bsc_init, priv_grant, priv_fault;
	logic power_on_reset_n, manual_reset_n, bus_request;
	int bad_count = 0, checked = 0;
	logic [31:0] expq[$];

	always #50 clock = ~clock;

	psm_ext_party i_psm_ext_party (.clock(clock), .por_cmd(por_cmd), .man_cmd(man_cmd), .want_bus(want_bus),
		.hold_cycles(hold_cycles), .bus_grant(bus_grant), .power_on_reset_n(power_on_reset_n),
		.manual_reset_n(manual_reset_n), .bus_request(bus_request));
	psm_ctrl i_psm_ctrl (.clock(clock), .rst_n(rst_n), .power_on_reset_n(power_on_reset_n),
		.manual_reset_n(manual_reset_n), .bus_request(bus_request), .exc_request(exc_request),
		.exc_offset(exc_offset), .current_pc(current_pc), .vector_base(vector_base), .exc_return(exc_return),
		.sleep_request(sleep_request), .sleep_mode(sleep_mode), .wake_event(wake_event),
		.priv_access(priv_access), .status_load(status_load), .status_wdata(status_wdata), .state(state),
		.status_word(status_word), .privilege_mode_bit(privilege_mode_bit), .saved_pc_reg(saved_pc_reg),
		.saved_status_reg(saved_status_reg), .fetch_addr(fetch_addr), .fetch_load(fetch_load),
		.exec_enable(exec_enable), .bus_grant(bus_grant), .module_init(module_init), .bsc_init(bsc_init),
		.pd_mode(pd_mode), .priv_grant(priv_grant), .priv_fault(priv_fault));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict;
		$display("Checks %0d, mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic step;
		@(posedge clock);
		#1;
	endtask

	// Bounded wait so a stuck state shows up as a mismatch, not a hang
	task automatic wait_state(input psm_state_t s, input int n);
		int i;
		for (i = 0; i < n && state !== s; i++) step();
		check(state, s);
	endtask

	task automatic take_exc(input logic [31:0] off);
		exc_offset = off;
		current_pc = $urandom;
		expq.push_back(vector_base + off);
		exp_ssr = status_word;
		exc_request = 1;
		step();
		exc_request = 0;
		check(state, PSM_ST_EXCEPTION);
		check(saved_pc_reg, current_pc);
		check(saved_status_reg, exp_ssr);
		check(status_word[PSM_MODE_BIT_POS], 1'b1);
		step();
		check(state, PSM_ST_EXECUTE);
		check(privilege_mode_bit, 1'b1);
	endtask

	task automatic ret;
		expq.push_back(saved_pc_reg);
		exc_return = 1;
		step();
		exc_return = 0;
		check(status_word[PSM_MODE_BIT_POS], 1'b0);
		step();
		check(privilege_mode_bit, 1'b0);
	endtask

	// Each fetch pulse takes the oldest expected address off the queue
	always @(negedge clock) begin
		if (fetch_load === 1'b1) begin
			if (expq.size() == 0) check(fetch_addr, 32'hXXXXXXXX);
			else check(fetch_addr, expq.pop_front());
		end
	end

	initial begin
		#400000;
		bad_count++;
		print_verdict();
	end

	initial begin
		int i;
		void'($urandom(32'h3b22e6a8));
		expq.push_back(PSM_RESET_VECTOR);
		step();
		step();
		rst_n = 1;
		wait_state(PSM_ST_EXECUTE, 8);
		check(privilege_mode_bit, 1'b1);
		$display("Test reset_exit done");
		for (i = 0; i < 3; i++) begin
			vector_base = $urandom;
			take_exc($urandom);
			take_exc($urandom);
			ret();
		end
		$display("Test exceptions done");
		priv_access = 1;
		step();
		priv_access = 0;
		expq.push_back(vector_base + PSM_PRIV_VIOL_OFFSET);
		check(priv_fault, 1'b1);
		wait_state(PSM_ST_EXECUTE, 4);
		priv_access = 1;
		step();
		priv_access = 0;
		check({priv_grant, priv_fault}, 2'b10);
		status_wdata = 32'h70000000;
		status_load = 1;
		step();
		status_load = 0;
		check(status_word, 32'h70000000);
		ret();
		status_wdata = $urandom;
		status_load = 1;
		step();
		status_load = 0;
		check(status_word, 32'h30000000);
		$display("Test privilege done");
		for (i = 0; i < 3; i++) begin
			sleep_mode = psm_pd_mode_t'(i);
			sleep_request = 1;
			step();
			sleep_request = 0;
			check({state, pd_mode, exec_enable}, {PSM_ST_POWER_DOWN, sleep_mode, 1'b0});
			wake_event = 1;
			step();
			wake_event = 0;
			check(state, PSM_ST_EXECUTE);
		end
		$display("Test power_down done");
		hold_cycles = 4'($urandom_range(2, 6));
		want_bus = 1;
		wait_state(PSM_ST_BUS_RELEASED, 8);
		check({bus_grant, exec_enable}, 2'b10);
		exc_request = 1;
		step();
		exc_request = 0;
		wait_state(PSM_ST_EXECUTE, 16);
		check(bus_grant, 1'b0);
		want_bus = 0;
		$display("Test bus_release done");
		man_cmd = 1;
		wait_state(PSM_ST_MAN_RESET, 8);
		check({module_init, bsc_init}, 2'b10);
		expq.push_back(PSM_RESET_VECTOR);
		man_cmd = 0;
		wait_state(PSM_ST_EXECUTE, 10);
		check(status_word[PSM_MODE_BIT_POS], 1'b1);
		por_cmd = 1;
		man_cmd = 1;
		wait_state(PSM_ST_PON_RESET, 8);
		check({module_init, bsc_init}, 2'b11);
		expq.push_back(PSM_RESET_VECTOR);
		por_cmd = 0;
		man_cmd = 0;
		wait_state(PSM_ST_EXECUTE, 12);
		check(expq.size(), 0);
		$display("Test pin_resets done");
		print_verdict();
	end
endmodule // tb_psm_ctrl
`default_nettype wire
